// >>> design/bvs_pkg.sv
// constants and types for the buck voltage setting register bank
// Function
// R1: ceiling bits 7-6 select output voltage range
// R2: setpoint writes above ceiling become the ceiling
// R3: ceiling not 0x3F/0x00 locks range and ceiling
// R4: power-on reset returns registers to reset contents
// R5: enable bit off stops converter; global off overrides
// R6: primary bit 7 reads zero; software writes zero
// R7: setpoint bits 5-0 are a voltage code
// R8: range codes map to bases and step sizes
// R9: power-saving and choice bits reset zero, passed through
package bvs_pkg;
  localparam logic [7:0]  ADDR_BUCK2_CEIL = 8'h09;
  localparam logic [7:0]  ADDR_BUCK3_PRI  = 8'h0A;
  localparam logic [7:0]  ADDR_BUCK3_ALT  = 8'h0B;
  localparam logic [7:0]  ADDR_BUCK3_CEIL = 8'h0C;
  localparam logic [7:0]  ADDR_BUCK4_PRI  = 8'h0D;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
  localparam int          RANGE_HI        = 7;
  localparam int          RANGE_LO        = 6;
  localparam int          CODE_HI         = 5;
  localparam int          CODE_LO         = 0;
  localparam int          ENABLE_BIT      = 7;
  localparam int          PSAVE_BIT       = 6;
  localparam int          CHOICE_BIT      = 6;
  localparam int          RESERVED_BIT_BIT        = 7;
  localparam logic [5:0]  CEIL_OPEN       = 6'h3F;
  localparam logic [5:0]  CEIL_ZERO       = 6'h00;
  localparam logic [1:0]  RANGE_FINE_LOW  = 2'h0;
  localparam logic [1:0]  RANGE_FINE_HIGH = 2'h1;
  localparam logic [1:0]  RANGE_MEDIUM    = 2'h2;
  localparam logic [1:0]  RANGE_COARSE    = 2'h3;
  // voltages in units of 0.5 mV
  localparam logic [12:0] V_BASE_500MV    = 13'h03E8;
  localparam logic [12:0] V_BASE_700MV    = 13'h0578;
  localparam logic [12:0] V_STEP_12MV5    = 13'h0019;
  localparam logic [12:0] V_STEP_25MV     = 13'h0032;
  localparam logic [12:0] V_STEP_50MV     = 13'h0064;

  typedef struct packed {
    logic [7:0] buck2_ceiling;
    logic [7:0] buck3_setpoint_primary;
    logic [7:0] buck3_setpoint_alternate;
    logic [7:0] buck3_ceiling;
    logic [7:0] buck4_setpoint_primary;
  } bvs_defaults_t;

  typedef struct packed {
    logic        register_choice_bit;
    logic [1:0]  range;
    logic [5:0]  code;
    logic [12:0] volt_half_mv;
  } bvs_setpoint_t;
endpackage : bvs_pkg

// >>> design/bvs_regs.sv
// register bank holding buck converter voltage settings
module bvs_regs (
  input  wire logic                   CLK_IN,        // 200 MHz clock
  input  wire logic                   RESET_IN,      // power-on reset, sync
  input  wire logic                   OTP_LOAD_IN,   // reload defaults pulse
  input  wire bvs_pkg::bvs_defaults_t OTP_DATA_IN,   // default contents
  input  wire logic                   WR_EN_IN,      // register write strobe
  input  wire logic [7:0]             WR_ADDR_IN,    // write offset
  input  wire logic [7:0]             WR_DATA_IN,    // write data
  input  wire logic [7:0]             RD_ADDR_IN,    // read offset
  input  wire logic                   GLOBAL_OFF_IN, // global power-off
  input  wire logic [7:0]             B4_CEIL_IN,    // buck_four ceiling
  output logic [7:0]                  RD_DATA_OUT,   // read data, registered
  output logic [7:0]                  B2_CEIL_OUT,   // buck_two ceiling
  output logic                        B2_LOCK_OUT,   // buck_two ceiling lock
  output logic                        B3_LOCK_OUT,   // buck_three lock
  output logic                        B3_RUN_OUT,    // buck_three runs
  output logic                        B3_PSAVE_OUT,  // buck_three power save
  output bvs_pkg::bvs_setpoint_t      B3_PRI_OUT,    // buck_three primary
  output bvs_pkg::bvs_setpoint_t      B3_ALT_OUT,    // buck_three alternate
  output bvs_pkg::bvs_setpoint_t      B4_PRI_OUT     // buck_four primary
);

  logic [7:0]             b2_ceil_reg,  b2_ceil_next;
  logic [7:0]             b3_pri_reg,   b3_pri_next;
  logic [7:0]             b3_alt_reg,   b3_alt_next;
  logic [7:0]             b3_ceil_reg,  b3_ceil_next;
  logic [7:0]             b4_pri_reg,   b4_pri_next;
  logic [7:0]             rd_data_reg,  rd_data_next;
  logic                   run_reg,      run_next;
  bvs_pkg::bvs_setpoint_t sp_reg [3];
  bvs_pkg::bvs_setpoint_t sp_next [3];
  logic                   b2_lock_reg,  b2_lock_next;
  logic                   b3_lock_reg,  b3_lock_next;
  logic [7:0]             sp_raw [3];
  logic [7:0]             sp_ceil [3];

  // a ceiling of all ones or all zeros means not yet programmed
  function automatic logic is_locked(input logic [7:0] ceil);
    logic [5:0] c;
    c = ceil[bvs_pkg::CODE_HI:bvs_pkg::CODE_LO];
    return (c != bvs_pkg::CEIL_OPEN) && (c != bvs_pkg::CEIL_ZERO);
  endfunction

  function automatic logic [5:0] clamp(input logic [7:0] data,
                                       input logic [7:0] ceil);
    logic [5:0] d;
    logic [5:0] c;
    d = data[bvs_pkg::CODE_HI:bvs_pkg::CODE_LO];
    c = ceil[bvs_pkg::CODE_HI:bvs_pkg::CODE_LO];
    return (d > c) ? c : d; // R2
  endfunction

  function automatic logic [12:0] decode(input logic [1:0] range,
                                         input logic [5:0] code);
    logic [12:0] base;
    logic [12:0] step;
    logic [12:0] span;
    base = bvs_pkg::V_BASE_500MV;
    step = bvs_pkg::V_STEP_12MV5;
    case (range) // R8
      bvs_pkg::RANGE_FINE_LOW: begin
        base = bvs_pkg::V_BASE_500MV;
        step = bvs_pkg::V_STEP_12MV5;
      end
      bvs_pkg::RANGE_FINE_HIGH: begin
        base = bvs_pkg::V_BASE_700MV;
        step = bvs_pkg::V_STEP_12MV5;
      end
      bvs_pkg::RANGE_MEDIUM: begin
        base = bvs_pkg::V_BASE_500MV;
        step = bvs_pkg::V_STEP_25MV;
      end
      default: begin
        base = bvs_pkg::V_BASE_500MV;
        step = bvs_pkg::V_STEP_50MV;
      end
    endcase
    // product kept at 13 bits: the largest code times 50 mV still fits
    span = 13'({7'h00, code} * step);
    return 13'(base + span); // R7
  endfunction

  // lock flags follow the next ceiling, so flag and ceiling move together
  assign b2_lock_next = is_locked(b2_ceil_next); // R3
  assign b3_lock_next = is_locked(b3_ceil_next); // R3

  // clamp on a setpoint write, with lock honoured on ceilings
  always_comb begin
    b2_ceil_next = b2_ceil_reg;
    b3_pri_next  = b3_pri_reg;
    b3_alt_next  = b3_alt_reg;
    b3_ceil_next = b3_ceil_reg;
    b4_pri_next  = b4_pri_reg;
    if (OTP_LOAD_IN) begin
      // reload overrides the lock, so apart from reset the lock ends only here
      b2_ceil_next = OTP_DATA_IN.buck2_ceiling; // R3
      b3_ceil_next = OTP_DATA_IN.buck3_ceiling; // R3
      b3_pri_next  = {1'b0,
                      OTP_DATA_IN.buck3_setpoint_primary[bvs_pkg::CHOICE_BIT],
                      clamp(OTP_DATA_IN.buck3_setpoint_primary,
                            OTP_DATA_IN.buck3_ceiling)};
      b3_alt_next  = {
        OTP_DATA_IN.buck3_setpoint_alternate[bvs_pkg::ENABLE_BIT],
        OTP_DATA_IN.buck3_setpoint_alternate[bvs_pkg::PSAVE_BIT],
        clamp(OTP_DATA_IN.buck3_setpoint_alternate,
              OTP_DATA_IN.buck3_ceiling)};
      b4_pri_next  = {1'b0,
                      OTP_DATA_IN.buck4_setpoint_primary[bvs_pkg::CHOICE_BIT],
                      clamp(OTP_DATA_IN.buck4_setpoint_primary,
                            B4_CEIL_IN)};
    end else if (WR_EN_IN) begin
      case (WR_ADDR_IN)
        bvs_pkg::ADDR_BUCK2_CEIL: begin
          if (!b2_lock_reg) begin
            b2_ceil_next = WR_DATA_IN; // R3
          end
        end
        bvs_pkg::ADDR_BUCK3_CEIL: begin
          if (!b3_lock_reg) begin
            b3_ceil_next = WR_DATA_IN; // R3
          end
        end
        bvs_pkg::ADDR_BUCK3_PRI: begin
          // reserved bit dropped even if software sets it
          b3_pri_next = {1'b0, WR_DATA_IN[bvs_pkg::CHOICE_BIT],
                         clamp(WR_DATA_IN, b3_ceil_reg)}; // R2 R6 R9
        end
        bvs_pkg::ADDR_BUCK3_ALT: begin
          b3_alt_next = {WR_DATA_IN[bvs_pkg::ENABLE_BIT],
                         WR_DATA_IN[bvs_pkg::PSAVE_BIT],
                         clamp(WR_DATA_IN, b3_ceil_reg)}; // R2 R9
        end
        bvs_pkg::ADDR_BUCK4_PRI: begin
          b4_pri_next = {1'b0, WR_DATA_IN[bvs_pkg::CHOICE_BIT],
                         clamp(WR_DATA_IN, B4_CEIL_IN)}; // R2 R6 R9
        end
        default: begin
          b2_ceil_next = b2_ceil_reg;
        end
      endcase
    end
  end

  // read port answers the cycle after the address is presented
  always_comb begin
    case (RD_ADDR_IN)
      bvs_pkg::ADDR_BUCK2_CEIL: rd_data_next = b2_ceil_reg;
      bvs_pkg::ADDR_BUCK3_PRI:  rd_data_next = b3_pri_reg; // R6
      bvs_pkg::ADDR_BUCK3_ALT:  rd_data_next = b3_alt_reg;
      bvs_pkg::ADDR_BUCK3_CEIL: rd_data_next = b3_ceil_reg;
      bvs_pkg::ADDR_BUCK4_PRI:  rd_data_next = b4_pri_reg; // R6
      default:                  rd_data_next = bvs_pkg::READ_UNMAPPED;
    endcase
  end

  assign sp_raw[0]  = b3_pri_reg;
  assign sp_raw[1]  = b3_alt_reg;
  assign sp_raw[2]  = b4_pri_reg;
  assign sp_ceil[0] = b3_ceil_reg;
  assign sp_ceil[1] = b3_ceil_reg;
  assign sp_ceil[2] = B4_CEIL_IN;

  // the alternate register has no choice bit, its bit 6 is power save
  for (genvar i = 0; i < 3; i++) begin : g_decode
    always_comb begin
      sp_next[i].register_choice_bit =
        (i == 1) ? 1'b0 : sp_raw[i][bvs_pkg::CHOICE_BIT]; // R9
      sp_next[i].range =
        sp_ceil[i][bvs_pkg::RANGE_HI:bvs_pkg::RANGE_LO]; // R1
      sp_next[i].code =
        sp_raw[i][bvs_pkg::CODE_HI:bvs_pkg::CODE_LO]; // R7
      sp_next[i].volt_half_mv = decode(
        sp_ceil[i][bvs_pkg::RANGE_HI:bvs_pkg::RANGE_LO],
        sp_raw[i][bvs_pkg::CODE_HI:bvs_pkg::CODE_LO]); // R1 R7
    end
    // decoded view lags its register one edge, keeping the adder off the bus
    always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
        sp_reg[i] <= '0; // R4
      end else begin
        sp_reg[i] <= sp_next[i];
      end
    end
  end

  assign run_next = b3_alt_reg[bvs_pkg::ENABLE_BIT] & ~GLOBAL_OFF_IN; // R5

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      b2_ceil_reg <= bvs_pkg::REG_RESET; // R4
      b3_pri_reg  <= bvs_pkg::REG_RESET; // R4
      b3_alt_reg  <= bvs_pkg::REG_RESET; // R4 R9
      b3_ceil_reg <= bvs_pkg::REG_RESET; // R4
      b4_pri_reg  <= bvs_pkg::REG_RESET; // R4 R9
      rd_data_reg <= bvs_pkg::READ_UNMAPPED;
      run_reg     <= 1'b0;
      b2_lock_reg <= 1'b0; // R4
      b3_lock_reg <= 1'b0; // R4
    end else begin
      b2_ceil_reg <= b2_ceil_next;
      b3_pri_reg  <= b3_pri_next;
      b3_alt_reg  <= b3_alt_next;
      b3_ceil_reg <= b3_ceil_next;
      b4_pri_reg  <= b4_pri_next;
      rd_data_reg <= rd_data_next;
      run_reg     <= run_next;
      b2_lock_reg <= b2_lock_next;
      b3_lock_reg <= b3_lock_next;
    end
  end

  assign RD_DATA_OUT  = rd_data_reg;
  assign B2_CEIL_OUT  = b2_ceil_reg;
  assign B2_LOCK_OUT  = b2_lock_reg;
  assign B3_LOCK_OUT  = b3_lock_reg;
  assign B3_RUN_OUT   = run_reg;
  assign B3_PSAVE_OUT = b3_alt_reg[bvs_pkg::PSAVE_BIT]; // R9
  assign B3_PRI_OUT   = sp_reg[0];
  assign B3_ALT_OUT   = sp_reg[1];
  assign B4_PRI_OUT   = sp_reg[2];

endmodule // bvs_regs

// >>> dv/bvs_regs_monitor.sv
// assertion checker bound to the buck voltage setting register bank
module bvs_regs_monitor (
  input wire logic                   CLK_IN,
  input wire logic                   RESET_IN,
  input wire logic                   OTP_LOAD_IN,
  input wire logic                   WR_EN_IN,
  input wire logic [7:0]             WR_ADDR_IN,
  input wire logic [7:0]             WR_DATA_IN,
  input wire logic [7:0]             RD_ADDR_IN,
  input wire logic                   GLOBAL_OFF_IN,
  input wire logic [7:0]             B4_CEIL_IN,
  input wire logic [7:0]             RD_DATA_OUT,
  input wire logic [7:0]             B2_CEIL_OUT,
  input wire logic                   B2_LOCK_OUT,
  input wire logic                   B3_RUN_OUT,
  input wire bvs_pkg::bvs_setpoint_t B3_PRI_OUT,
  input wire bvs_pkg::bvs_setpoint_t B3_ALT_OUT,
  input wire bvs_pkg::bvs_setpoint_t B4_PRI_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0]  rg;
  logic [12:0] v_exp;
  assign rg = B3_PRI_OUT.range;
  assign v_exp = (rg == 2'h1 ? 13'h0578 : 13'h03E8) + 13'(B3_PRI_OUT.code)
    * (rg[1] ? (rg[0] ? 13'h0064 : 13'h0032) : 13'h0019);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  property p_lock; B2_LOCK_OUT == (B2_CEIL_OUT[5:0] != 6'h3F
    && B2_CEIL_OUT[5:0] != 6'h00); endproperty
  property p_hold; B2_LOCK_OUT && WR_EN_IN && !OTP_LOAD_IN
    && WR_ADDR_IN == 8'h09 |=> $stable(B2_CEIL_OUT); endproperty
  property p_off; GLOBAL_OFF_IN |=> !B3_RUN_OUT; endproperty
  property p_reserved_bit; RD_ADDR_IN == 8'h0A || RD_ADDR_IN == 8'h0D
    |=> !RD_DATA_OUT[7]; endproperty
  property p_clamp; WR_EN_IN && !OTP_LOAD_IN && WR_ADDR_IN == 8'h0D
    && WR_DATA_IN[5:0] > B4_CEIL_IN[5:0]
    |=> ##1 B4_PRI_OUT.code == $past(B4_CEIL_IN[5:0], 2); endproperty
  // decoded outputs lag the registers by one edge after reset
  property p_volt; !$past(RESET_IN) |-> B3_PRI_OUT.volt_half_mv == v_exp;
  endproperty
  property p_range; B3_PRI_OUT.range == B3_ALT_OUT.range; endproperty
  property p_por; $past(RESET_IN) |-> RD_DATA_OUT == 8'h00
    && B2_CEIL_OUT == 8'h00 && !B3_RUN_OUT; endproperty
  a_lock: assert property (p_lock) else $error("lock flag wrong");
  a_hold: assert property (p_hold) else $error("locked ceiling moved");
  a_off: assert property (p_off) else $error("runs in global off");
  a_reserved_bit: assert property (p_reserved_bit) else $error("reserved bit set");
  a_clamp: assert property (p_clamp) else $error("code not clamped");
  a_volt: assert property (p_volt) else $error("voltage decode wrong");
  a_range: assert property (p_range) else $error("range mismatch");
  a_por: assert property (p_por) else $error("reset contents wrong");
  c_lock: cover property (B2_LOCK_OUT);
  c_off: cover property (GLOBAL_OFF_IN ##1 !B3_RUN_OUT);
  c_load: cover property (OTP_LOAD_IN);
endmodule // bvs_regs_monitor

bind bvs_regs bvs_regs_monitor bvs_regs_monitor_inst (.CLK_IN(CLK_IN),
  .RESET_IN(RESET_IN), .OTP_LOAD_IN(OTP_LOAD_IN), .WR_EN_IN(WR_EN_IN),
  .WR_ADDR_IN(WR_ADDR_IN), .WR_DATA_IN(WR_DATA_IN), .RD_ADDR_IN(RD_ADDR_IN),
  .GLOBAL_OFF_IN(GLOBAL_OFF_IN), .B4_CEIL_IN(B4_CEIL_IN),
  .RD_DATA_OUT(RD_DATA_OUT), .B2_CEIL_OUT(B2_CEIL_OUT),
  .B2_LOCK_OUT(B2_LOCK_OUT), .B3_RUN_OUT(B3_RUN_OUT),
  .B3_PRI_OUT(B3_PRI_OUT), .B3_ALT_OUT(B3_ALT_OUT), .B4_PRI_OUT(B4_PRI_OUT));

// >>> dv/tb_top.sv
// self-checking bench for the buck voltage setting register bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk = 0, rst = 1, load = 0, wr_en = 0, goff = 0;
  logic [7:0]             wa = 0, wd = 0, ra = 0, b4c = 8'h08, rdat, b2c;
  logic                   b2l, b3l, run, psv;
  bvs_pkg::bvs_defaults_t otp = '0;
  bvs_pkg::bvs_setpoint_t pri, alt, b4p;
  int                     error_cnt = 0, comparisons = 0;
  initial forever #2.5 clk = ~clk;
  bvs_regs bvs_regs_inst (.CLK_IN(clk), .RESET_IN(rst), .OTP_LOAD_IN(load),
    .OTP_DATA_IN(otp), .WR_EN_IN(wr_en), .WR_ADDR_IN(wa), .WR_DATA_IN(wd),
    .RD_ADDR_IN(ra), .GLOBAL_OFF_IN(goff), .B4_CEIL_IN(b4c),
    .RD_DATA_OUT(rdat), .B2_CEIL_OUT(b2c), .B2_LOCK_OUT(b2l),
    .B3_LOCK_OUT(b3l), .B3_RUN_OUT(run), .B3_PSAVE_OUT(psv),
    .B3_PRI_OUT(pri), .B3_ALT_OUT(alt), .B4_PRI_OUT(b4p));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1;
    wa = a;
    wd = d;
    @(negedge clk);
    wr_en = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    ra = a;
    @(negedge clk);
    chk(rdat, e);
  endtask
  task automatic vchk(input bvs_pkg::bvs_setpoint_t s, input logic [1:0] r,
                      input logic [5:0] c);
    logic [12:0] base, step;
    base = (r == 2'h1) ? bvs_pkg::V_BASE_700MV : bvs_pkg::V_BASE_500MV;
    step = r[1] ? (r[0] ? bvs_pkg::V_STEP_50MV : bvs_pkg::V_STEP_25MV)
                : bvs_pkg::V_STEP_12MV5;
    chk({s.range, s.code}, {r, c});
    chk(s.volt_half_mv, base + 13'(c) * step);
  endtask
  task automatic give_verdict;
    $display("counts: errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // generous bound: the sequence needs fewer than a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    for (int a = 9; a <= 16; a++) rd(a[7:0], 8'h00);
    // open ceiling keeps the bank unlocked while every range is tried
    for (int r = 0; r < 4; r++) begin
      wr(8'h0C, {r[1:0], 6'h3F});
      wr(8'h0A, 8'h4A);
      repeat (2) @(negedge clk);
      vchk(pri, r[1:0], 6'h0A);
      chk(b3l, 1'b0);
    end
    chk(pri.register_choice_bit, 1'b1);
    wr(8'h0C, 8'hC5);
    chk(b3l, 1'b1);
    wr(8'h0C, 8'h3F);
    rd(8'h0C, 8'hC5);
    wr(8'h0A, 8'h7F);
    rd(8'h0A, 8'h45);
    wr(8'h0B, 8'hC7);
    rd(8'h0B, 8'hC5);
    vchk(alt, 2'h3, 6'h05);
    chk(alt.register_choice_bit, 1'b0);
    chk({psv, run}, 2'b11);
    vchk(pri, 2'h3, 6'h05);
    goff = 1;
    repeat (2) @(negedge clk);
    chk(run, 1'b0);
    goff = 0;
    wr(8'h0D, 8'h7C);
    rd(8'h0D, 8'h48);
    vchk(b4p, 2'h0, 6'h08);
    chk(b4p.register_choice_bit, 1'b1);
    // buck_four range follows its ceiling input, code stays as stored
    b4c = 8'hC8;
    repeat (2) @(negedge clk);
    vchk(b4p, 2'h3, 6'h08);
    wr(8'h09, 8'h40);
    chk({b2l, b2c}, 9'h040);
    wr(8'h09, 8'h92);
    wr(8'h09, 8'h3F);
    chk({b2l, b2c}, 9'h192);
    otp = {8'h3F, 8'hA0, 8'h80, 8'h10, 8'h05};
    @(negedge clk);
    load = 1;
    @(negedge clk);
    load = 0;
    rd(8'h0A, 8'h10);
    chk({b2l, b2c}, 9'h03F);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 8'h10);
    chk({run, b3l}, 2'b11);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    rd(8'h0C, 8'h00);
    chk(b3l, 1'b0);
    give_verdict;
  end
endmodule // tb_top
